// [src/wps_pkg.sv]
// constants for the wireless power packet sequencer
package wps_pkg;
  // packet header codes
  localparam logic [7:0] HDR_SIG_STRENGTH = 8'h01;
  localparam logic [7:0] HDR_END_POWER    = 8'h02;
  localparam logic [7:0] HDR_CTRL_ERROR   = 8'h03;
  localparam logic [7:0] HDR_RECT_POWER   = 8'h04;
  localparam logic [7:0] HDR_CHG_STATUS   = 8'h05;
  localparam logic [7:0] HDR_HOLD_OFF     = 8'h06;
  localparam logic [7:0] HDR_PROP_LO      = 8'h18;
  localparam logic [7:0] HDR_PROP_HI      = 8'hf2;
  localparam logic [7:0] HDR_CONFIG       = 8'h51;
  localparam logic [7:0] HDR_IDENT        = 8'h71;
  localparam logic [7:0] HDR_EXT_IDENT    = 8'h81;
  // position of the extension flag in the identification payload
  localparam int EXT_BIT_POS = 7;
  localparam int MAX_OPTIONAL = 7;
  // timing, in microseconds, and cycle counts at 40 MHz
  localparam int CLK_MHZ         = 40;
  localparam int PING_WAIT_US    = 65;
  localparam int NEXT_PKT_US     = 21000;
  localparam int FIRST_CE_US     = 170000;
  localparam int CE_INTERVAL_US  = 1800000;
  localparam int RECT_PWR_US     = 23000000;
  localparam int REMOVE_DLY_US   = 28000;
  localparam int SETTLE_US       = 5000;
  localparam int PING_WAIT_CYC   = PING_WAIT_US * CLK_MHZ;
  localparam int NEXT_PKT_CYC    = NEXT_PKT_US * CLK_MHZ;
  localparam int FIRST_CE_CYC    = FIRST_CE_US * CLK_MHZ;
  localparam int CE_INTERVAL_CYC = CE_INTERVAL_US * CLK_MHZ;
  localparam int RECT_PWR_CYC    = RECT_PWR_US * CLK_MHZ;
  localparam int REMOVE_DLY_CYC  = REMOVE_DLY_US * CLK_MHZ;
  localparam int SETTLE_CYC      = SETTLE_US * CLK_MHZ;
  localparam int ping_freq_khz   = 175;
  localparam logic [7:0] PING_FREQ_KHZ = 8'haf;
  localparam logic [6:0] DUTY_HALF     = 7'h32;
  typedef enum logic [2:0] {
    WPS_SELECT, WPS_PING, WPS_IDCFG, WPS_XFER, WPS_REMOVE
  } wps_phase_t;
endpackage

// [src/wps_sequencer.sv]
// transmitter phase sequencer checking receiver packet order and timing
`timescale 1ns/1ps
module wps_sequencer #(
  parameter int PING_WAIT   = wps_pkg::PING_WAIT_CYC,
  parameter int NEXT_PKT    = wps_pkg::NEXT_PKT_CYC,
  parameter int FIRST_CE    = wps_pkg::FIRST_CE_CYC,
  parameter int CE_INTERVAL = wps_pkg::CE_INTERVAL_CYC,
  parameter int RECT_PWR    = wps_pkg::RECT_PWR_CYC,
  parameter int REMOVE_DLY  = wps_pkg::REMOVE_DLY_CYC,
  parameter int SETTLE      = wps_pkg::SETTLE_CYC
) (
  input  wire logic       clk,          // 40 MHz clock
  input  wire logic       rst,          // async reset, high
  input  wire logic       sel_found,    // selection saw a receiver
  input  wire logic       hdr_start,    // header start bit seen
  input  wire logic       pkt_valid,    // good packet, at stop bit
  input  wire logic       pkt_error,    // bad checksum or parity
  input  wire logic [7:0] pkt_header,   // header byte
  input  wire logic [7:0] pkt_byte0,    // first payload byte
  input  wire logic [7:0] pkt_byte1,    // second payload byte
  output logic            power_on,     // power signal enabled
  output logic [2:0]      phase,        // current phase code
  output logic            op_fixed,     // fixed ping operating point
  output logic [7:0]      fixed_khz,    // fixed frequency, kHz
  output logic [6:0]      fixed_duty,   // fixed duty, percent
  output logic            ce_apply,     // pulse: apply adjustment
  output logic [7:0]      ce_value,     // signed control error
  output logic [7:0]      sig_strength, // last strength value
  output logic            end_request,  // end power requested
  output logic            fault         // pulse: sequence abort, not end power during transfer
);
  localparam int TW = 31;
  initial begin
    if (PING_WAIT < 2 || NEXT_PKT < 2 || FIRST_CE < 2 || CE_INTERVAL < 2 ||
        RECT_PWR < 2 || REMOVE_DLY < 2 || SETTLE < 2)
      $error("wps_sequencer timing parameter too small");
  end

  wps_pkg::wps_phase_t state, next_state;
  logic [1:0] id_step;   // 0 want ident, 1 want ext, 2 optionals
  logic [2:0] opt_cnt;
  logic       ext_req;
  logic       rect_seen;
  logic       ce_seen;
  logic [7:0] ce_hold;

  // header classes
  wire is_ss   = pkt_header == wps_pkg::HDR_SIG_STRENGTH;
  wire is_id   = pkt_header == wps_pkg::HDR_IDENT;
  wire is_ext  = pkt_header == wps_pkg::HDR_EXT_IDENT;
  wire is_cfg  = pkt_header == wps_pkg::HDR_CONFIG;
  wire is_ce   = pkt_header == wps_pkg::HDR_CTRL_ERROR;
  wire is_rp   = pkt_header == wps_pkg::HDR_RECT_POWER;
  wire is_cs   = pkt_header == wps_pkg::HDR_CHG_STATUS;
  wire is_ep   = pkt_header == wps_pkg::HDR_END_POWER;
  // defined codes inside the proprietary span keep their own meaning
  wire is_prop = pkt_header >= wps_pkg::HDR_PROP_LO &&
                 pkt_header <= wps_pkg::HDR_PROP_HI &&
                 !is_id && !is_ext && !is_cfg;
  // any header not defined elsewhere counts as reserved
  wire is_known = is_ss | is_id | is_ext | is_cfg | is_ce | is_rp |
                  is_cs | is_ep | (pkt_header == wps_pkg::HDR_HOLD_OFF);
  wire is_opt  = (pkt_header == wps_pkg::HDR_HOLD_OFF) || is_prop ||
                 !is_known;

  wire in_ping = state == wps_pkg::WPS_PING;
  wire in_id   = state == wps_pkg::WPS_IDCFG;
  wire in_xfer = state == wps_pkg::WPS_XFER;
  wire ext_set = pkt_byte0[wps_pkg::EXT_BIT_POS];

  // identification order check
  wire id_ok = (id_step == 2'd0 && is_id) ||
               (id_step == 2'd1 && is_ext) ||
               (id_step == 2'd2 && is_cfg) ||
               (id_step == 2'd2 && is_opt &&
                opt_cnt < 3'(wps_pkg::MAX_OPTIONAL));
  wire id_bad = in_id && pkt_valid && !id_ok;
  wire id_done = in_id && pkt_valid && id_step == 2'd2 && is_cfg;
  wire xfer_ok = is_ce | is_rp | is_cs | is_ep | is_prop | !is_known;
  wire xfer_bad = in_xfer && pkt_valid && !xfer_ok;
  wire ping_bad = in_ping && pkt_valid && !is_ss;

  // timers: start-bit wait, first/next control error, rectified power, removal delay, settling
  logic t_hdr_fire, t_ce_fire, t_rp_fire, t_rm_fire, t_st_fire;
  wire  enter_ping = state == wps_pkg::WPS_SELECT && sel_found;
  // the strength packet's stop bit also opens the next start-bit window
  wire  hdr_load = enter_ping || (in_ping && pkt_valid && is_ss) ||
                   (in_id && pkt_valid && id_ok && !is_cfg);
  wire  [TW-1:0] hdr_cnt = enter_ping ? TW'(PING_WAIT) : TW'(NEXT_PKT);
  wire  ce_load = id_done || (in_xfer && pkt_valid && is_ce);
  wire  [TW-1:0] ce_cnt = id_done ? TW'(FIRST_CE) : TW'(CE_INTERVAL);
  wire  abort = ping_bad | id_bad | xfer_bad | (in_xfer && pkt_error) |
                (t_hdr_fire && (in_ping || in_id)) |
                (t_ce_fire && in_xfer) |
                (t_rp_fire && in_xfer) |
                (in_xfer && pkt_valid && is_ep);
  wire  leave = state == wps_pkg::WPS_REMOVE;

  wps_timer #(.W(TW)) u_hdr (
    .clk(clk), .rst(rst), .load(hdr_load),
    .stop(hdr_start || abort || leave), .count(hdr_cnt), .fire(t_hdr_fire));
  wps_timer #(.W(TW)) u_ce (
    .clk(clk), .rst(rst), .load(ce_load), .stop(abort || leave),
    .count(ce_cnt), .fire(t_ce_fire));
  wps_timer #(.W(TW)) u_rp (
    .clk(clk), .rst(rst), .load(id_done),
    .stop((in_xfer && pkt_valid && is_rp) || abort || leave),
    .count(TW'(RECT_PWR)), .fire(t_rp_fire));
  wps_timer #(.W(TW)) u_rm (
    .clk(clk), .rst(rst), .load(abort), .stop(1'b0),
    .count(TW'(REMOVE_DLY)), .fire(t_rm_fire));
  wps_timer #(.W(TW)) u_st (
    .clk(clk), .rst(rst), .load(in_xfer && pkt_valid && is_ce),
    .stop(abort || leave), .count(TW'(SETTLE)), .fire(t_st_fire));

  always_comb begin
    next_state = state;
    unique case (state)
      wps_pkg::WPS_SELECT: if (sel_found) next_state = wps_pkg::WPS_PING;
      wps_pkg::WPS_PING: begin
        if (abort) next_state = wps_pkg::WPS_REMOVE;
        else if (pkt_valid && is_ss) next_state = wps_pkg::WPS_IDCFG;
      end
      wps_pkg::WPS_IDCFG: begin
        if (abort) next_state = wps_pkg::WPS_REMOVE;
        else if (id_done) next_state = wps_pkg::WPS_XFER;
      end
      wps_pkg::WPS_XFER: if (abort) next_state = wps_pkg::WPS_REMOVE;
      // power stays until the removal delay runs out, then reselect
      wps_pkg::WPS_REMOVE:
        if (t_rm_fire) next_state = wps_pkg::WPS_SELECT;
      default: next_state = wps_pkg::WPS_SELECT;
    endcase
  end

  // in ping the strength packet must open the next phase directly
  wire ss_taken = in_ping && pkt_valid && is_ss;
  wire [1:0] next_step = !is_id ? 2'd2 : (ext_set ? 2'd1 : 2'd2);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state   <= wps_pkg::WPS_SELECT;
      id_step <= 2'd0;
      opt_cnt <= 3'd0;
      ext_req <= 1'b0;
    end else begin
      state <= next_state;
      if (ss_taken) begin
        id_step <= 2'd0;
        opt_cnt <= 3'd0;
        ext_req <= 1'b0;
      end else if (in_id && pkt_valid && id_ok) begin
        if (id_step != 2'd2) id_step <= next_step;
        if (is_id) ext_req <= ext_set;
        if (id_step == 2'd2 && is_opt) opt_cnt <= opt_cnt + 3'd1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rect_seen <= 1'b0;
      ce_seen   <= 1'b0;
      ce_hold   <= 8'h00;
    end else begin
      if (id_done) begin
        rect_seen <= 1'b0;
        ce_seen   <= 1'b0;
      end else if (in_xfer && pkt_valid) begin
        if (is_rp) rect_seen <= 1'b1;
        if (is_ce) begin
          ce_seen <= 1'b1;
          ce_hold <= pkt_byte0;
        end
      end
    end
  end

  // registered outputs
  wire fixed_pt = in_ping || in_id;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      power_on     <= 1'b0;
      phase        <= 3'd0;
      op_fixed     <= 1'b0;
      fixed_khz    <= 8'h00;
      fixed_duty   <= 7'h00;
      ce_apply     <= 1'b0;
      ce_value     <= 8'h00;
      sig_strength <= 8'h00;
      end_request  <= 1'b0;
      fault        <= 1'b0;
    end else begin
      power_on   <= next_state != wps_pkg::WPS_SELECT &&
                    !(state == wps_pkg::WPS_REMOVE && t_rm_fire);
      phase      <= 3'(next_state);
      op_fixed   <= fixed_pt;
      fixed_khz  <= wps_pkg::PING_FREQ_KHZ;
      fixed_duty <= wps_pkg::DUTY_HALF;
      ce_apply   <= t_st_fire && in_xfer;
      if (t_st_fire && in_xfer) ce_value <= ce_hold;
      if (ss_taken) sig_strength <= pkt_byte0;
      end_request <= in_xfer && pkt_valid && is_ep;
      fault       <= abort && !in_xfer | (abort && !(pkt_valid && is_ep));
    end
  end

  chk_ping_fixed_point: assert property (@(posedge clk) disable iff (rst)
    in_ping |=> op_fixed && fixed_khz == 8'haf)
    else $error("ping operating point not fixed");
  chk_idcfg_fixed_point: assert property (@(posedge clk) disable iff (rst)
    in_id |=> op_fixed && fixed_duty == 7'h32)
    else $error("identification operating point not fixed");
  chk_ping_advance: assert property (@(posedge clk) disable iff (rst)
    in_ping && pkt_valid && is_ss |=> state == wps_pkg::WPS_IDCFG)
    else $error("strength packet did not advance");
  chk_ping_wrong_pkt: assert property (@(posedge clk) disable iff (rst)
    ping_bad |=> state == wps_pkg::WPS_REMOVE ##1 power_on)
    else $error("wrong ping packet not aborted");
  chk_start_timeout: assert property (@(posedge clk) disable iff (rst)
    t_hdr_fire && (in_ping || in_id) |=> state == wps_pkg::WPS_REMOVE)
    else $error("start bit timeout ignored");
  chk_idcfg_order: assert property (@(posedge clk) disable iff (rst)
    id_bad |=> state == wps_pkg::WPS_REMOVE)
    else $error("out of order packet accepted");
  chk_opt_limit: assert property (@(posedge clk) disable iff (rst)
    in_id && pkt_valid && id_step == 2'd2 && is_opt && opt_cnt == 3'd7
    |=> state == wps_pkg::WPS_REMOVE)
    else $error("optional packet count exceeded");
  chk_rp_stopped: assert property (@(posedge clk) disable iff (rst)
    in_xfer && rect_seen |-> !t_rp_fire)
    else $error("rectified power timeout after packet seen");
  chk_ext_expect: assert property (@(posedge clk) disable iff (rst)
    in_id && pkt_valid && is_id && !ext_set && id_step == 2'd0
    |=> id_step == 2'd2)
    else $error("extended identification wrongly expected");
  chk_ce_timeout: assert property (@(posedge clk) disable iff (rst)
    t_ce_fire && in_xfer |=> state == wps_pkg::WPS_REMOVE)
    else $error("control error timeout ignored");
  chk_rp_timeout: assert property (@(posedge clk) disable iff (rst)
    t_rp_fire && in_xfer |=> state == wps_pkg::WPS_REMOVE)
    else $error("rectified power timeout ignored");
  chk_xfer_violation: assert property (@(posedge clk) disable iff (rst)
    xfer_bad |=> !in_xfer)
    else $error("transfer violation accepted");
  chk_settle_apply: assert property (@(posedge clk) disable iff (rst)
    ce_apply |-> $past(ce_seen))
    else $error("adjustment without control error");
  chk_xfer_accept: assert property (@(posedge clk) disable iff (rst)
    in_xfer && pkt_valid && (is_cs || is_rp) && !abort |=> in_xfer)
    else $error("allowed transfer packet rejected");
endmodule // wps_sequencer

// [src/wps_timer.sv]
// loadable down counter with expiry pulse
`timescale 1ns/1ps
module wps_timer #(
  parameter int W = 30
) (
  input  wire logic         clk,   // system clock
  input  wire logic         rst,   // async reset
  input  wire logic         load,  // start or restart
  input  wire logic         stop,  // disarm
  input  wire logic [W-1:0] count, // cycles to expiry
  output logic              fire   // one-cycle expiry
);
  logic [W-1:0] left;
  logic         armed;
  wire          at_one = armed && (left == W'(1));
  initial begin
    if (W < 2 || W > 31) $error("wps_timer width out of range");
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      left  <= '0;
      armed <= 1'b0;
      fire  <= 1'b0;
    end else begin
      fire <= at_one && !load && !stop;
      if (load) begin
        left  <= count;
        armed <= 1'b1;
      end else if (stop || at_one) begin
        armed <= 1'b0;
      end else if (armed) begin
        left <= left - W'(1);
      end
    end
  end
endmodule // wps_timer

// [tb/test_wps_sequencer.sv]
// self-checking bench for the packet sequencer
`timescale 1ns/1ps
module test_wps_sequencer;
  localparam int PW = 50, NP = 50, FC = 100, CI = 100, RD = 10, ST = 5;
  logic        clk, rst, sel_found, pkt_error, hdr_start, pkt_valid;
  logic        power_on, op_fixed, ce_apply, end_request, fault;
  logic [7:0]  pkt_header, pkt_byte0, pkt_byte1, fixed_khz, ce_value;
  logic [7:0]  sig_strength, b;
  logic [6:0]  fixed_duty;
  logic [2:0]  phase;
  logic [15:0] lq = 16'h4238;
  logic        ext, flt_seen, end_seen;
  int          err_total, n_checks, ep, stage, nopt, cyc, k, j, d;
  int          ce_t[$];
  logic [7:0]  ce_v[$];
  wps_sequencer #(.PING_WAIT(PW), .NEXT_PKT(NP), .FIRST_CE(FC),
    .CE_INTERVAL(CI), .RECT_PWR(400), .REMOVE_DLY(RD), .SETTLE(ST)) i_dut (
    .clk(clk), .rst(rst), .sel_found(sel_found), .hdr_start(hdr_start),
    .pkt_valid(pkt_valid), .pkt_error(pkt_error), .pkt_header(pkt_header),
    .pkt_byte0(pkt_byte0), .pkt_byte1(pkt_byte1), .power_on(power_on),
    .phase(phase), .op_fixed(op_fixed), .fixed_khz(fixed_khz),
    .fixed_duty(fixed_duty), .ce_apply(ce_apply), .ce_value(ce_value),
    .sig_strength(sig_strength), .end_request(end_request), .fault(fault));
  wps_rx_model i_rx (.clk(clk), .hdr_start(hdr_start),
    .pkt_valid(pkt_valid), .pkt_header(pkt_header),
    .pkt_byte0(pkt_byte0), .pkt_byte1(pkt_byte1));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  function automatic logic [7:0] rnd();
    lq = {lq[14:0], lq[15] ^ lq[13] ^ lq[12] ^ lq[10]};
    return lq[7:0];
  endfunction
  function automatic logic [7:0] opt_hdr(input int n);
    logic [7:0] h;
    h = wps_pkg::HDR_PROP_LO + 8'(rnd() % 8'd219);
    if (h inside {8'h51, 8'h71, 8'h81}) h = 8'h20;
    if (n == 0) h = wps_pkg::HDR_HOLD_OFF;
    if (n == 1) h = 8'h07;
    return h;
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string what);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // reference phase model
  task automatic ref_pkt(input logic [7:0] h, input logic [7:0] b0);
    logic kn;
    kn = h inside {8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h51, 8'h71, 8'h81};
    if (ep == 1) ep = (h == wps_pkg::HDR_SIG_STRENGTH) ? 2 : 4;
    else if (ep == 3)
      ep = (h inside {8'h01, 8'h06, 8'h51, 8'h71, 8'h81}) ? 4 : 3;
    else if (stage == 0 && h == wps_pkg::HDR_IDENT) begin
      ext = b0[wps_pkg::EXT_BIT_POS];
      stage = ext ? 1 : 2;
    end else if (stage == 1 && h == wps_pkg::HDR_EXT_IDENT) stage = 2;
    else if (stage == 2 && h == wps_pkg::HDR_CONFIG) ep = 3;
    else if (stage == 2 && !kn && nopt < wps_pkg::MAX_OPTIONAL) nopt++;
    else ep = 4;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (fault === 1'b1) flt_seen <= 1'b1;
    if (end_request === 1'b1) end_seen <= 1'b1;
    if (pkt_valid === 1'b1 && phase === 3'h3 &&
        pkt_header === wps_pkg::HDR_CTRL_ERROR) begin
      ce_t.push_back(cyc);
      ce_v.push_back(pkt_byte0);
    end
    if (ce_apply === 1'b1 && ce_t.size() > 0) begin
      d = cyc - ce_t.pop_front();
      chk({7'h0, d == ST + 2 || d == ST + 3}, 8'h01, "ce delay");
      chk(ce_value, ce_v.pop_front(), "ce value");
    end
  end
  task automatic pkt(input logic [7:0] h, input logic [7:0] b0);
    i_rx.send(h, b0, 2);
    ref_pkt(h, b0);
    @(negedge clk);
    chk({5'h0, phase}, 8'(ep), "phase");
    if (ep == 4) chk({7'h0, power_on}, 8'h01, "delay");
  endtask
  task automatic off(input logic cf);
    for (k = 0; k < RD + 20 && (power_on !== 1'b0 || phase !== 3'h0); k++)
      @(negedge clk);
    chk({7'h0, power_on}, 8'h00, "power");
    chk({5'h0, phase}, 8'h00, "idle");
    if (cf) chk({7'h0, flt_seen}, 8'h01, "fault");
    ep = 0;
    ce_t.delete();
    ce_v.delete();
  endtask
  task automatic start();
    flt_seen = 1'b0;
    end_seen = 1'b0;
    stage = 0;
    nopt = 0;
    ep = 1;
    sel_found = 1'b1;
    @(negedge clk);
    sel_found = 1'b0;
    @(negedge clk);
    chk({5'h0, phase}, 8'h01, "ping");
    chk({7'h0, power_on}, 8'h01, "on");
    chk(fixed_khz, wps_pkg::PING_FREQ_KHZ, "khz");
    chk({1'b0, fixed_duty}, {1'b0, wps_pkg::DUTY_HALF}, "duty");
  endtask
  task automatic tmo(input int lim);
    repeat (lim - 5) @(negedge clk);
    chk({5'h0, phase}, 8'(ep), "early");
    for (k = 0; k < 15 && phase !== 3'h4; k++) @(negedge clk);
    chk({5'h0, phase}, 8'h04, "late");
    off(1'b1);
  endtask
  task automatic to_xfer();
    start();
    pkt(8'h01, rnd());
    pkt(8'h71, 8'h00);
    pkt(8'h51, 8'h00);
  endtask
  task automatic done(input string s);
    $display("test %s done", s);
  endtask
  initial begin
    #(25 * 40000);
    err_total++;
    close_out();
  end
  initial begin
    rst = 1'b1;
    sel_found = 1'b0;
    pkt_error = 1'b0;
    repeat (16) @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    start();
    b = rnd();
    pkt(8'h01, b);
    chk(sig_strength, b, "strength");
    chk({7'h0, op_fixed}, 8'h01, "fixed");
    pkt(8'h71, 8'h80);
    pkt(8'h81, rnd());
    for (j = 0; j < 7; j++) pkt(opt_hdr(j), rnd());
    chk({7'h0, op_fixed}, 8'h01, "fixed");
    pkt(8'h51, 8'h00);
    pkt(8'h03, rnd());
    repeat (ST + 6) @(negedge clk);
    pkt(8'h04, rnd());
    pkt(8'h05, rnd());
    pkt(8'h20, rnd());
    pkt(8'h03, rnd());
    repeat (ST + 6) @(negedge clk);
    chk(8'(ce_t.size()), 8'h00, "applied");
    i_rx.send(8'h02, 8'h00, 2);
    repeat (2) @(negedge clk);
    chk({7'h0, end_seen}, 8'h01, "end");
    off(1'b0);
    done("transfer");
    start();
    tmo(PW);
    start();
    pkt(8'h71, 8'h00);
    off(1'b1);
    done("ping");
    start();
    pkt(8'h01, rnd());
    pkt(8'h71, 8'h00);
    pkt(8'h81, 8'h00);
    off(1'b1);
    start();
    pkt(8'h01, rnd());
    pkt(8'h71, 8'h00);
    for (j = 0; j < 8; j++) pkt(opt_hdr(j), rnd());
    off(1'b1);
    start();
    pkt(8'h01, rnd());
    tmo(NP);
    done("idcfg");
    to_xfer();
    tmo(FC);
    to_xfer();
    pkt(8'h03, rnd());
    tmo(CI);
    to_xfer();
    for (j = 0; j < 12 && phase === 3'h3; j++) i_rx.send(8'h03, rnd(), 60);
    chk(8'(j), 8'h07, "rect wait");
    off(1'b1);
    to_xfer();
    pkt(8'h51, 8'h00);
    off(1'b1);
    to_xfer();
    pkt_error = 1'b1;
    @(negedge clk);
    pkt_error = 1'b0;
    @(negedge clk);
    chk({5'h0, phase}, 8'h04, "error");
    off(1'b1);
    done("timing");
    close_out();
  end
endmodule // test_wps_sequencer

// [tb/wps_rx_model.sv]
// receiver-side packet source feeding the demodulator outputs
`timescale 1ns/1ps
module wps_rx_model (
  input  wire logic clk,        // bench clock
  output logic       hdr_start,  // header start bit pulse
  output logic       pkt_valid,  // good packet at stop bit
  output logic [7:0] pkt_header, // header byte
  output logic [7:0] pkt_byte0,  // payload byte 0
  output logic [7:0] pkt_byte1   // payload byte 1
);
  initial begin
    hdr_start  = 1'b0;
    pkt_valid  = 1'b0;
    pkt_header = 8'h00;
    pkt_byte0  = 8'h00;
    pkt_byte1  = 8'h00;
  end
  // caller picks header order and gap; fields idle inverted, never stale
  task automatic send(input logic [7:0] h, input logic [7:0] b0,
                      input int gap);
    repeat (gap) @(negedge clk);
    hdr_start = 1'b1;
    @(negedge clk);
    hdr_start = 1'b0;
    repeat (2) @(negedge clk);
    pkt_header = h;
    pkt_byte0  = b0;
    pkt_byte1  = ~b0;
    pkt_valid  = 1'b1;
    @(negedge clk);
    pkt_valid  = 1'b0;
    pkt_header = ~h;
    pkt_byte0  = ~b0;
    pkt_byte1  = b0;
  endtask
endmodule // wps_rx_model
